// ===== rtl/gdp_pkg.sv
/*
  Shared constants, types and the register decoder for the auxiliary
  GPIO data port and watchdog control slice.
  Assumes one 20 MHz clock and an APB master with 32-bit data.
*/
// Notes on behaviour
// R1: Enabled force line rising edge forces timeout
// R2: Force-timeout bit works regardless of line enable
// R3: One timeout per rising edge, no retrigger
// R4: Self-clearing edge pulse ORed with force bit
// R5: Bit 4 enables secondary watchdog, default off
// R6: Software writes zeros to bits 7:5
// R7: Group-1 register bits map to pins 0-7
// R8: Group-2 register bits 0-5 only, 6-7 reserved
// R9: Group-4 register implements only bit 7
// R10: Group-6 register bits map to pins 0-7
// R11: Group-7 register bits map to pins 0-7
// R12: Low alias indices outside configuration mode
// R13: Input pin read latches pin with polarity
// R14: Writes to input pins are ignored
// R15: Output pin driven by bit with polarity
// R16: Output pin read returns stored bit
// R17: Force bit write-only, self-clearing, single event
// R18: Status reads 1 after any timeout event
// R19: Direction and polarity come from outside inputs
package gdp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] GDP_IDX_WDT = 8'hF4;
  localparam logic [7:0] GDP_IDX_GRP1 = 8'hF6;
  localparam logic [7:0] GDP_IDX_GRP2 = 8'hF7;
  localparam logic [7:0] GDP_IDX_GRP4 = 8'hF8;
  localparam logic [7:0] GDP_IDX_GRP6 = 8'hFA;
  localparam logic [7:0] GDP_IDX_GRP7 = 8'hFB;
  localparam logic [7:0] GDP_ALS_GRP1 = 8'h01;
  localparam logic [7:0] GDP_ALS_GRP2 = 8'h02;
  localparam logic [7:0] GDP_ALS_WDT = 8'h03;
  localparam logic [7:0] GDP_ALS_GRP4 = 8'h04;
  localparam logic [7:0] GDP_ALS_GRP6 = 8'h05;
  localparam logic [7:0] GDP_ALS_GRP7 = 8'h06;

  // Slots of the five pin groups
  localparam logic [2:0] GDP_SLOT_G1 = 3'h0;
  localparam logic [2:0] GDP_SLOT_G2 = 3'h1;
  localparam logic [2:0] GDP_SLOT_G4 = 3'h2;
  localparam logic [2:0] GDP_SLOT_G6 = 3'h3;
  localparam logic [2:0] GDP_SLOT_G7 = 3'h4;

  typedef logic [4:0][7:0] gdp_pins_t;

  // Implemented pins per slot, slot 4 leftmost
  localparam gdp_pins_t GDP_GPIO_MASK = 40'hFF_FF80_3FFF;
  localparam gdp_pins_t GDP_GPIO_RST = 40'h00_0000_0000;

  // Watchdog control fields
  localparam int GDP_WDT_STATUS = 0;
  localparam int GDP_WDT_LED = 1;
  localparam int GDP_WDT_FORCE = 2;
  localparam int GDP_WDT_KBC_EN = 3;
  localparam int GDP_WDT_SECONDARY_SMI_WATCHDOG_EN = 4;
  localparam logic [7:0] GDP_WDT_STORE_MASK = 8'h1B;
  localparam logic [7:0] GDP_WDT_RST = 8'h00;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } gdp_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } gdp_apb_rsp_s;

  typedef struct packed {
    logic hit;
    logic wdt;
    logic [2:0] slot;
  } gdp_dec_s;

  typedef struct packed {
    gdp_pins_t data;
    gdp_pins_t pin_out;
    gdp_pins_t pin_oe;
    logic [7:0] watchdog_control;
    logic timeout;
    logic pready;
    logic pslverr;
    logic [7:0] rdata;
  } gdp_top_s;

  typedef struct packed {
    logic prev;
    logic pulse;
  } gdp_edge_s;

  function automatic gdp_dec_s gdp_decode(input logic [11:0] paddr, input logic cfg);
    gdp_dec_s d;
    d = '0;
    if (paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0) begin
      d.hit = 1'b1;
      if (cfg) begin
        case (paddr[9:2])
          GDP_IDX_WDT: d.wdt = 1'b1;
          GDP_IDX_GRP1: d.slot = GDP_SLOT_G1;
          GDP_IDX_GRP2: d.slot = GDP_SLOT_G2;
          GDP_IDX_GRP4: d.slot = GDP_SLOT_G4;
          GDP_IDX_GRP6: d.slot = GDP_SLOT_G6;
          GDP_IDX_GRP7: d.slot = GDP_SLOT_G7;
          default: d.hit = 1'b0;
        endcase
      end else begin
        case (paddr[9:2])
          GDP_ALS_WDT: d.wdt = 1'b1;
          GDP_ALS_GRP1: d.slot = GDP_SLOT_G1;
          GDP_ALS_GRP2: d.slot = GDP_SLOT_G2;
          GDP_ALS_GRP4: d.slot = GDP_SLOT_G4;
          GDP_ALS_GRP6: d.slot = GDP_SLOT_G6;
          GDP_ALS_GRP7: d.slot = GDP_SLOT_G7;
          default: d.hit = 1'b0;
        endcase
      end
    end
    return d;
  endfunction : gdp_decode

endpackage : gdp_pkg

// ===== rtl/gdp_edge.sv
/*
  Self-clearing rising-edge detector for the keyboard force line.
  Assumes the line is synchronous to clk_i.
*/
`timescale 1ns/100ps
module gdp_edge
  import gdp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic line_i,
  input wire logic en_i,
  output logic pulse_o
);

  gdp_edge_s s_q;
  gdp_edge_s s_d;

  always_comb begin
    s_d = s_q;
    // Level always tracked, so enabling while high cannot fire
    s_d.prev = line_i;
    s_d.pulse = en_i & line_i & ~s_q.prev; // R1 R3
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse_o = s_q.pulse;

  one_per_edge_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
    pulse_o |=> !pulse_o)
    else $error("edge pulse lasted more than one cycle");

endmodule : gdp_edge

// ===== rtl/gdp_top.sv
/*
  GPIO data registers and watchdog control tail, reached over APB.
  Assumes pin direction, polarity and pin levels synchronous to clk_i,
  and an external watchdog counter reporting expiry on wdt_expire_i.
*/
`timescale 1ns/100ps
module gdp_top
  import gdp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cfg_mode_i,
  input wire gdp_apb_req_s apb_i,
  output gdp_apb_rsp_s apb_o,
  input wire gdp_pins_t pin_dir_i,
  input wire gdp_pins_t pin_pol_i,
  input wire gdp_pins_t pin_i,
  output gdp_pins_t pin_o,
  output gdp_pins_t pin_oe_o,
  input wire logic kbc_force_line_i,
  input wire logic wdt_expire_i,
  output logic wdt_status_o,
  output logic led_toggle_en_o,
  output logic secondary_smi_watchdog_enable_o,
  output logic wdt_timeout_o
);

  gdp_top_s s_q;
  gdp_top_s s_d;
  gdp_dec_s dec;
  logic setup;
  logic done;
  logic force_req;
  logic kbc_pulse;
  logic trigger;
  logic [7:0] rd_byte;
  logic [7:0] wr_keep;

  // Assertions below share this clock and reset
  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (!rst_n_i);

  gdp_edge u_edge (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .line_i(kbc_force_line_i),
    .en_i(s_q.watchdog_control[GDP_WDT_KBC_EN]), // R1
    .pulse_o(kbc_pulse)
  );

  always_comb begin
    dec = gdp_decode(apb_i.paddr, cfg_mode_i); // R12
    setup = apb_i.psel & ~apb_i.penable;
    done = apb_i.psel & apb_i.penable & s_q.pready;
  end

  always_comb begin
    force_req = done & apb_i.pwrite & dec.hit & dec.wdt
      & apb_i.pwdata[GDP_WDT_FORCE];
  end

  // Byte seen by a read: outputs show the register, inputs the pin
  always_comb begin
    rd_byte = 8'h00;
    if (dec.wdt) begin
      // Force bit never reads back
      rd_byte = s_q.watchdog_control & GDP_WDT_STORE_MASK; // R17
    end else begin
      rd_byte = s_q.data[dec.slot] & pin_dir_i[dec.slot]; // R16 R19
      rd_byte = rd_byte | ((pin_i[dec.slot] ^ pin_pol_i[dec.slot])
        & ~pin_dir_i[dec.slot]); // R13
      rd_byte = rd_byte & GDP_GPIO_MASK[dec.slot]; // R8 R9
    end
  end

  // Bits of the addressed group that a write must leave alone
  always_comb begin
    wr_keep = ~(pin_dir_i[dec.slot] & GDP_GPIO_MASK[dec.slot]); // R14
  end

  always_comb begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.timeout = 1'b0;

    // Answer is prepared in the setup cycle, so no wait states
    if (setup) begin
      s_d.pready = 1'b1;
      s_d.pslverr = ~dec.hit;
      s_d.rdata = 8'h00;
      if (dec.hit && !apb_i.pwrite) begin
        s_d.rdata = rd_byte;
        if (!dec.wdt) begin
          // Input bits are latched by the read itself
          s_d.data[dec.slot] = rd_byte; // R13
        end
      end
    end

    if (done && apb_i.pwrite && dec.hit) begin
      if (dec.wdt) begin
        s_d.watchdog_control = apb_i.pwdata[7:0] & GDP_WDT_STORE_MASK; // R5 R6
      end else begin
        s_d.data[dec.slot] = (s_q.data[dec.slot] & wr_keep)
          | (apb_i.pwdata[7:0] & ~wr_keep); // R7 R8 R9 R10 R11 R14
      end
    end

    // Line pulse and force bit share one trigger
    trigger = kbc_pulse | force_req; // R2 R4 R17
    s_d.timeout = trigger;

    // Event beats a software clear in the same cycle
    if (trigger || wdt_expire_i) begin
      s_d.watchdog_control[GDP_WDT_STATUS] = 1'b1; // R18
    end

    s_d.pin_out = (s_d.data ^ pin_pol_i) & GDP_GPIO_MASK; // R15
    s_d.pin_oe = pin_dir_i & GDP_GPIO_MASK; // R15 R19
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q.data <= GDP_GPIO_RST;
      s_q.pin_out <= GDP_GPIO_RST;
      s_q.pin_oe <= GDP_GPIO_RST;
      s_q.watchdog_control <= GDP_WDT_RST; // R5
      s_q.timeout <= 1'b0;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.rdata <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_o.pready = s_q.pready;
  assign apb_o.pslverr = s_q.pslverr;
  assign apb_o.prdata = {24'h00_0000, s_q.rdata};
  assign pin_o = s_q.pin_out;
  assign pin_oe_o = s_q.pin_oe;
  assign wdt_status_o = s_q.watchdog_control[GDP_WDT_STATUS];
  assign led_toggle_en_o = s_q.watchdog_control[GDP_WDT_LED];
  assign secondary_smi_watchdog_enable_o = s_q.watchdog_control[GDP_WDT_SECONDARY_SMI_WATCHDOG_EN];
  assign wdt_timeout_o = s_q.timeout;

  // Checks

  logic kbc_en;
  logic wdt_wr;
  logic wdt_rd;
  logic [7:0] cur_grp;

  assign cur_grp = s_q.data[dec.slot];
  assign kbc_en = s_q.watchdog_control[GDP_WDT_KBC_EN];
  assign wdt_wr = done & apb_i.pwrite & dec.hit & dec.wdt;
  assign wdt_rd = setup & ~apb_i.pwrite & dec.hit & dec.wdt;

  sequence apb_setup_s;
    apb_i.psel && !apb_i.penable;
  endsequence

  sequence ready_once_s;
    apb_o.pready ##1 !apb_o.pready;
  endsequence

  apb_no_wait_a: assert property (apb_setup_s |=> ready_once_s)
    else $error("apb answer not a single ready cycle");

  unmapped_err_a: assert property ( // R12
    apb_i.psel && !apb_i.penable && !dec.hit |=> apb_o.pslverr)
    else $error("unmapped index did not raise pslverr");

  sequence kbc_edge_s;
    kbc_en && $rose(kbc_force_line_i);
  endsequence

  kbc_force_a: assert property (kbc_edge_s |=> ##1 wdt_timeout_o && wdt_status_o) // R1
    else $error("enabled line edge did not force a timeout");

  kbc_off_a: assert property ( // R1
    (!kbc_en && $rose(kbc_force_line_i)) ##1 !force_req |=> !wdt_timeout_o)
    else $error("disabled line edge forced a timeout");

  no_retrigger_a: assert property ( // R3
    kbc_force_line_i [*3] ##0 !force_req |=> !wdt_timeout_o)
    else $error("held line retriggered a timeout");

  // A line pulse right behind the write is a second legal event
  force_bit_a: assert property ( // R2 R17
    force_req ##1 !kbc_pulse |-> wdt_timeout_o ##1 !wdt_timeout_o)
    else $error("force bit did not give one timeout pulse");

  status_set_a: assert property (wdt_expire_i |=> wdt_status_o) // R18
    else $error("status not set after expiry");

  secondary_smi_watchdog_write_a: assert property (wdt_wr |=> // R5
    secondary_smi_watchdog_enable_o == $past(apb_i.pwdata[GDP_WDT_SECONDARY_SMI_WATCHDOG_EN]))
    else $error("secondary watchdog enable not written");

  wdt_rsvd_a: assert property (wdt_rd |=> apb_o.prdata[7:5] == 3'h0 // R6 R17
    && !apb_o.prdata[GDP_WDT_FORCE])
    else $error("reserved or force bit read as one");

  rsvd_pins_a: assert property ( // R8 R9
    pin_oe_o[GDP_SLOT_G2][7:6] == 2'h0 && pin_oe_o[GDP_SLOT_G4][6:0] == 7'h00)
    else $error("reserved pin driven");

  out_drive_a: assert property ( // R15
    (pin_dir_i == $past(pin_dir_i) && pin_pol_i == $past(pin_pol_i))
    |-> pin_o == ((s_q.data ^ $past(pin_pol_i)) & GDP_GPIO_MASK))
    else $error("output pin does not follow register and polarity");

  in_write_a: assert property ( // R14
    done && apb_i.pwrite && dec.hit && !dec.wdt
    |=> (s_q.data[$past(dec.slot)] & $past(wr_keep)) == ($past(cur_grp) & $past(wr_keep)))
    else $error("write changed an input or reserved pin bit");

endmodule : gdp_top

// ===== verification/gdp_pins_model.sv
/*
  Far-side model of the general-purpose pins.
  Assumes the bench supplies the level of every pin that the block does not drive.
*/
`timescale 1ns/100ps
module gdp_pins_model
  import gdp_pkg::*;
(
  input wire gdp_pins_t pin_o_i,
  input wire gdp_pins_t pin_oe_i,
  input wire gdp_pins_t ext_i,
  output gdp_pins_t pin_i_o
);
  // No pulls here: an undriven pin shows the outside level
  assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
endmodule : gdp_pins_model

// ===== verification/tb_top.sv
/*
  Self-checking bench for gdp_top: APB master task and one task per scenario.
  Assumes the pin model on the far side; the master waits on pready.
*/
`timescale 1ns/100ps
module tb_top;
  import gdp_pkg::*;
  logic clk_i, rst_n_i, cfg, kbc, expire, st, led, w2, tmo, err;
  gdp_apb_req_s req;
  gdp_apb_rsp_s rsp;
  gdp_pins_t dir, pol, pin_in, pout, poe, ext;
  int miscompares, n_checks, n_tmo;
  logic [31:0] rd;
  logic [7:0] idx [5] = '{GDP_IDX_GRP1, GDP_IDX_GRP2, GDP_IDX_GRP4, GDP_IDX_GRP6, GDP_IDX_GRP7};

  gdp_top gdp_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_mode_i(cfg), .apb_i(req),
    .apb_o(rsp), .pin_dir_i(dir), .pin_pol_i(pol), .pin_i(pin_in), .pin_o(pout),
    .pin_oe_o(poe), .kbc_force_line_i(kbc), .wdt_expire_i(expire), .wdt_status_o(st),
    .led_toggle_en_o(led), .secondary_smi_watchdog_enable_o(w2), .wdt_timeout_o(tmo));
  gdp_pins_model gdp_pins_model_inst (.pin_o_i(pout), .pin_oe_i(poe), .ext_i(ext),
    .pin_i_o(pin_in));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (tmo === 1'b1) n_tmo++;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Idle cycle first, so psel is never lowered and raised in one step
  task automatic apb(input logic wr, input logic [7:0] ix, input logic [7:0] wd);
    int i;
    @(posedge clk_i);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= {2'h0, ix, 2'h0};
    req.pwdata <= {24'h00_0000, wd};
    @(posedge clk_i);
    req.penable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk_i);
      if (rsp.pready === 1'b1) break;
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (i == 8) begin
      miscompares++;
      print_verdict();
    end
    // Outputs launched at the access edge settle before the caller looks
    @(posedge clk_i);
  endtask : apb

  task automatic t_reset();
    chk({st, led, w2, tmo}, 0);
    chk(poe[0], 0);
    apb(0, GDP_IDX_WDT, 0);
    chk(rd, 0);
    for (int s = 0; s < 5; s++) begin
      apb(0, idx[s], 0);
      chk(rd, 0);
    end
  endtask : t_reset

  task automatic t_out();
    dir <= '1;
    pol <= 40'hA5_5AA5_C33C;
    for (int s = 0; s < 5; s++) begin
      apb(1, idx[s], 8'h96 ^ 8'(s));
      apb(0, idx[s], 0);
      chk(rd, (8'h96 ^ 8'(s)) & GDP_GPIO_MASK[s]);
      chk(pout[s], (8'h96 ^ 8'(s) ^ pol[s]) & GDP_GPIO_MASK[s]);
      chk(poe[s], GDP_GPIO_MASK[s]);
    end
  endtask : t_out

  task automatic t_in();
    dir <= '0;
    ext <= 40'h3C_5AA5_0FF0;
    for (int s = 0; s < 5; s++) begin
      apb(1, idx[s], ~(8'h96 ^ 8'(s)));
      chk(pout[s], (8'h96 ^ 8'(s) ^ pol[s]) & GDP_GPIO_MASK[s]);
      apb(0, idx[s], 0);
      chk(rd, (ext[s] ^ pol[s]) & GDP_GPIO_MASK[s]);
    end
  endtask : t_in

  task automatic t_alias();
    dir <= '1;
    cfg <= 1'b0;
    apb(1, GDP_ALS_GRP7, 8'hC3);
    apb(0, GDP_ALS_GRP7, 0);
    chk(rd, 32'h0000_00C3);
    apb(0, GDP_ALS_WDT, 0);
    chk(err, 0);
    apb(0, 8'h07, 0);
    chk(err, 1);
    chk(rd, 32'h0000_0000);
    apb(0, GDP_IDX_GRP1, 0);
    chk(err, 1);
    cfg <= 1'b1;
    apb(0, GDP_IDX_GRP7, 0);
    chk(err, 0);
    chk(rd, 32'h0000_00C3);
  endtask : t_alias

  task automatic t_wdt();
    apb(1, GDP_IDX_WDT, 8'h10);
    chk(w2, 1);
    n_tmo = 0;
    apb(1, GDP_IDX_WDT, 8'h14);
    repeat (3) @(posedge clk_i);
    chk(n_tmo, 1);
    chk(st, 1);
    apb(0, GDP_IDX_WDT, 0);
    chk(rd, 32'h0000_0011);
    apb(1, GDP_IDX_WDT, 8'h08);
    chk(st, 0);
    n_tmo = 0;
    kbc <= 1'b1;
    repeat (12) @(posedge clk_i);
    chk(n_tmo, 1);
    kbc <= 1'b0;
    apb(1, GDP_IDX_WDT, 8'h02);
    chk(led, 1);
    kbc <= 1'b1;
    repeat (6) @(posedge clk_i);
    kbc <= 1'b0;
    chk(n_tmo, 1);
    chk(st, 0);
    expire <= 1'b1;
    @(posedge clk_i);
    expire <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(st, 1);
  endtask : t_wdt

  initial begin
    rst_n_i = 1'b0;
    cfg = 1'b1;
    kbc = 1'b0;
    expire = 1'b0;
    req = '0;
    dir = '0;
    pol = '0;
    ext = '0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_out();
    t_in();
    t_alias();
    t_wdt();
    print_verdict();
  end
endmodule : tb_top
